/* rtl/ecw_ctrl_words.sv */
`timescale 1ns/1ps
`default_nettype none
module ecw_ctrl_words #(
  parameter int HOLD_A_CYC = ecw_pkg::HOLD_A_CYC,
  parameter int HOLD_B_CYC = ecw_pkg::HOLD_B_CYC,
  parameter int HOLD_C_CYC = ecw_pkg::HOLD_C_CYC,
  parameter int CNT_W      = 25
) (
  input  wire logic        mclk,            // Clock, 125 MHz
  input  wire logic        rst,             // Sync reset
  input  wire logic [3:0]  addr,            // Register address
  input  wire logic [15:0] wdata,           // Write data
  input  wire logic        wr,              // Write strobe
  input  wire logic        rd,              // Read strobe
  output logic      [15:0] rdata,           // Read data
  input  wire logic [7:0]  tx_pwr,          // Tx power, dB
  input  wire logic [7:0]  tx_flr,          // Tx noise floor, dB
  input  wire logic [7:0]  rx_pwr,          // Rx power, dB
  input  wire logic [7:0]  rx_flr,          // Rx noise floor, dB
  input  wire logic [1:0]  net_floor_set,   // Network noise floor
  input  wire logic        net_path_seen,   // Network path found
  input  wire logic        howl_seen,       // Howl pulse
  input  wire logic        train_done,      // Training finished
  output logic             tx_speech,       // Tx speech flag
  output logic             rx_speech,       // Rx speech flag
  output logic      [3:0]  hd_state,        // Engine state
  output logic             half_duplex,     // Half-duplex active
  output logic             retrain,         // Retrain pulse
  output logic      [9:0]  aec_taps,        // Acoustic taps
  output logic      [9:0]  nec_taps,        // Network taps
  output logic             nec_enable,      // Network canceller on
  output logic             nec_coef_clear,  // Hold coefs at zero
  output logic             nec_coef_freeze, // Stop adaptation
  output logic      [7:0]  tx_gain_db,      // Signed gain, dB
  output logic             tx_agc_en,       // Gain control active
  output logic             tx_mute,         // Tx path muted
  output logic      [4:0]  rx_atten_db,     // Rx suppression, dB
  output logic      [3:0]  noise_ramp,      // Rise rate, dB/s
  output logic             tx_decay_normal, // Tx decay fast
  output logic             rx_decay_normal  // Rx decay fast
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (HOLD_A_CYC < 1 || HOLD_B_CYC < 1 || HOLD_C_CYC < 1) begin : g_chk_min
    $error("holdover counts must be at least one cycle");
  end
  if (CNT_W > 30 || HOLD_A_CYC >= (1 << CNT_W) ||
      HOLD_B_CYC >= (1 << CNT_W) || HOLD_C_CYC >= (1 << CNT_W)) begin : g_chk_w
    $error("holdover counter too narrow");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0]     w1;
    logic [15:0]     w2;
    logic [15:0]     rdata;
    ecw_pkg::ecw_hd_e hd;
    logic            owner_rx;
    logic            half_duplex;
    logic            howl_latch;
    logic            nec_on;
    logic            retrain;
    logic            tx_sp;
    logic            rx_sp;
    logic [9:0]      aec_taps;
    logic [9:0]      nec_taps;
    logic            coef_clear;
    logic            coef_freeze;
    logic [7:0]      gain;
    logic            agc_en;
    logic            mute;
    logic [4:0]      atten;
    logic [3:0]      ramp;
    logic            tdec;
    logic            rdec;
  } ecw_top_s;

  ecw_top_s s_reg;
  ecw_top_s s_next;

  ecw_det_if txd ();
  ecw_det_if rxd ();
  ecw_det_if supd ();

  logic             hold_run;
  logic             hold_done;
  logic [CNT_W-1:0] hold_limit;
  logic [15:0]      status;

  // ----------------------------------------
  // Speech detectors
  // ----------------------------------------
  // Each detector sees its own threshold field
  assign txd.pwr  = tx_pwr;
  assign txd.flr  = tx_flr;
  assign txd.thr  = s_reg.w1[ecw_pkg::F_THR +: 2];
  assign rxd.pwr  = rx_pwr;
  assign rxd.flr  = rx_flr;
  assign rxd.thr  = s_reg.w2[ecw_pkg::F_THR +: 2];
  assign supd.pwr = rx_pwr;
  assign supd.flr = rx_flr;
  assign supd.thr = s_reg.w2[ecw_pkg::F_STHR +: 2];

  ecw_speech_det u_txd (
    .mclk (mclk),
    .rst  (rst),
    .d    (txd)
  );

  ecw_speech_det u_rxd (
    .mclk (mclk),
    .rst  (rst),
    .d    (rxd)
  );

  ecw_speech_det u_supd (
    .mclk (mclk),
    .rst  (rst),
    .d    (supd)
  );

  // ----------------------------------------
  // Holdover timer
  // ----------------------------------------
  // Reserved code falls back to the longest delay
  always_comb begin
    case (s_reg.w2[ecw_pkg::F_HOLD +: 2])
      2'h1:    hold_limit = CNT_W'(HOLD_B_CYC);
      2'h2:    hold_limit = CNT_W'(HOLD_C_CYC);
      default: hold_limit = CNT_W'(HOLD_A_CYC);
    endcase
  end

  assign hold_run = (s_reg.hd == ecw_pkg::HD_HOLD);

  ecw_hold_timer #(
    .CNT_W (CNT_W)
  ) u_hold (
    .mclk  (mclk),
    .rst   (rst),
    .run   (hold_run),
    .limit (hold_limit),
    .done  (hold_done)
  );

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Gain falls 3 dB per code from the top figure
  function automatic logic [7:0] gain_db(input logic [3:0] c);
    gain_db = ecw_pkg::GAIN_MAX_DB - 8'(ecw_pkg::GAIN_STEP * c);
  endfunction

  assign status = {8'h00, s_reg.hd, s_reg.half_duplex, s_reg.nec_on,
                   s_reg.tx_sp, s_reg.rx_sp};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.retrain = 1'b0;
    s_next.rdata = 16'h0000;

    // Writes land by code, foreign codes ignored
    if (wr && addr == ecw_pkg::OFS_CMD) begin
      if (wdata[3:0] == ecw_pkg::CODE_W1) begin
        s_next.w1 = wdata;
      end else if (wdata[3:0] == ecw_pkg::CODE_W2) begin
        s_next.w2 = wdata;
      end
    end

    // Read answer stands one cycle only
    if (rd) begin
      if (addr == ecw_pkg::OFS_CMD) begin
        s_next.rdata = s_reg.w1;
      end else if (addr == ecw_pkg::OFS_WORD2) begin
        s_next.rdata = s_reg.w2;
      end else if (addr == ecw_pkg::OFS_STAT) begin
        s_next.rdata = status;
      end
    end

    // Detector flags copied out
    s_next.tx_sp = txd.speech;
    s_next.rx_sp = rxd.speech;

    // Tap pool shared in fixed steps
    s_next.nec_taps = ecw_pkg::TAP_STEP *
                      (10'(s_reg.w1[ecw_pkg::F_TAPS +: 2]) + 10'h001);
    s_next.aec_taps = ecw_pkg::TAP_POOL - s_next.nec_taps;

    // Gain control only above unity; below it plain attenuation
    s_next.mute = (s_reg.w1[ecw_pkg::F_GAIN +: 4] == ecw_pkg::GAIN_MUTE);
    s_next.gain = s_next.mute ? 8'h00 : gain_db(s_reg.w1[ecw_pkg::F_GAIN +: 4]);
    s_next.agc_en = (s_reg.w1[ecw_pkg::F_GAIN +: 4] < ecw_pkg::GAIN_UNITY);

    // Rx suppression in unless the F_RSUP bit is set or far end is talking
    if (!s_reg.w1[ecw_pkg::F_RSUP] && !supd.speech) begin
      s_next.atten = ecw_pkg::RX_SUP_DB;
    end else begin
      s_next.atten = 5'h00;
    end

    // Coefficient control, reserved code treated as normal
    s_next.coef_clear = (s_reg.w1[ecw_pkg::F_NCC +: 2] == ecw_pkg::NCC_CLEAR);
    s_next.coef_freeze = (s_reg.w1[ecw_pkg::F_NCC +: 2] == ecw_pkg::NCC_FREEZE);

    // Ramp and decay settings
    s_next.ramp = ecw_pkg::RAMP_BASE << s_reg.w2[ecw_pkg::F_RAMP +: 2];
    s_next.tdec = s_reg.w2[ecw_pkg::F_TDEC];
    s_next.rdec = s_reg.w2[ecw_pkg::F_RDEC];

    // Training ends half-duplex unless a howl is held
    if (train_done && !s_reg.howl_latch) begin
      s_next.half_duplex = 1'b0;
    end
    if (!s_reg.w2[ecw_pkg::F_HOWL]) begin
      s_next.howl_latch = 1'b0;
    end

    // Network canceller drop and re-engage
    if (s_reg.nec_on && net_floor_set != 2'h0 && !net_path_seen) begin
      s_next.nec_on = 1'b0;
    end else if (!s_reg.nec_on && net_path_seen &&
                 !s_reg.w1[ecw_pkg::F_AUTO]) begin
      s_next.nec_on = 1'b1;
      s_next.half_duplex = 1'b1;
      s_next.retrain = 1'b1;
    end

    // Howl wins over the training release
    if (howl_seen) begin
      s_next.half_duplex = 1'b1;
      s_next.retrain = 1'b1;
      s_next.howl_latch = s_reg.w2[ecw_pkg::F_HOWL];
    end

    // Half-duplex ownership engine
    case (s_reg.hd)
      ecw_pkg::HD_IDLE: begin
        if (rxd.speech) begin
          s_next.hd = ecw_pkg::HD_RX;
        end else if (txd.speech || s_reg.w2[ecw_pkg::F_IDLE]) begin
          s_next.hd = ecw_pkg::HD_TX;
        end
      end
      ecw_pkg::HD_TX: begin
        if (!txd.speech) begin
          s_next.hd = ecw_pkg::HD_HOLD;
          s_next.owner_rx = 1'b0;
        end
      end
      ecw_pkg::HD_RX: begin
        if (!rxd.speech) begin
          s_next.hd = ecw_pkg::HD_HOLD;
          s_next.owner_rx = 1'b1;
        end
      end
      ecw_pkg::HD_HOLD: begin
        // Only the old owner may resume before the delay ends
        if (s_reg.owner_rx && rxd.speech) begin
          s_next.hd = ecw_pkg::HD_RX;
        end else if (!s_reg.owner_rx && txd.speech) begin
          s_next.hd = ecw_pkg::HD_TX;
        end else if (hold_done) begin
          s_next.hd = ecw_pkg::HD_IDLE;
        end
      end
      default: s_next.hd = ecw_pkg::HD_IDLE;
    endcase
    if (!s_reg.half_duplex) begin
      s_next.hd = ecw_pkg::HD_IDLE;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Half-duplex from reset while the filters train
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.w1 <= ecw_pkg::W1_RST;
      s_reg.w2 <= ecw_pkg::W2_RST;
      s_reg.hd <= ecw_pkg::HD_IDLE;
      s_reg.half_duplex <= 1'b1;
      s_reg.nec_on <= 1'b1;
      s_reg.nec_taps <= 10'h0c0;
      s_reg.aec_taps <= 10'h13c;
      s_reg.gain <= 8'h00;
      s_reg.atten <= ecw_pkg::RX_SUP_DB;
      s_reg.ramp <= ecw_pkg::RAMP_BASE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata           = s_reg.rdata;
  assign tx_speech       = s_reg.tx_sp;
  assign rx_speech       = s_reg.rx_sp;
  assign hd_state        = s_reg.hd;
  assign half_duplex     = s_reg.half_duplex;
  assign retrain         = s_reg.retrain;
  assign aec_taps        = s_reg.aec_taps;
  assign nec_taps        = s_reg.nec_taps;
  assign nec_enable      = s_reg.nec_on;
  assign nec_coef_clear  = s_reg.coef_clear;
  assign nec_coef_freeze = s_reg.coef_freeze;
  assign tx_gain_db      = s_reg.gain;
  assign tx_agc_en       = s_reg.agc_en;
  assign tx_mute         = s_reg.mute;
  assign rx_atten_db     = s_reg.atten;
  assign noise_ramp      = s_reg.ramp;
  assign tx_decay_normal = s_reg.tdec;
  assign rx_decay_normal = s_reg.rdec;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence reengage_cause;
    !nec_enable && net_path_seen && !s_reg.w1[ecw_pkg::F_AUTO];
  endsequence

  sequence reengage_effect;
    nec_enable && half_duplex && retrain;
  endsequence

  word_route_a: assert property (
    wr && addr == ecw_pkg::OFS_CMD && wdata[3:0] == ecw_pkg::CODE_W2
    |=> s_reg.w2 == $past(wdata) && $stable(s_reg.w1))
    else $error("second word not routed by code");

  read_back_a: assert property (
    rd && addr == ecw_pkg::OFS_CMD |=> rdata == $past(s_reg.w1) ##1
    ($past(rd) || rdata == 16'h0000))
    else $error("first word read back wrong");

  tap_pool_a: assert property (
    aec_taps + nec_taps == ecw_pkg::TAP_POOL)
    else $error("tap split does not fill the pool");

  tap_code_a: assert property (
    $past(s_reg.w1[ecw_pkg::F_TAPS +: 2]) == 2'h0 |-> nec_taps == 10'h040)
    else $error("network taps wrong for split code");

  rx_suppress_a: assert property (
    rx_atten_db != 5'h00 |-> rx_atten_db == ecw_pkg::RX_SUP_DB &&
    !$past(s_reg.w1[ecw_pkg::F_RSUP]) && !$past(supd.speech))
    else $error("rx suppression without cause");

  hold_owner_a: assert property (
    hd_state == ecw_pkg::HD_HOLD && !s_reg.owner_rx |=> hd_state != ecw_pkg::HD_RX)
    else $error("ownership changed during holdover");

  reengage_a: assert property (
    reengage_cause and !(nec_enable && net_floor_set != 2'h0) |=> reengage_effect)
    else $error("network canceller not re-engaged");

  floor_zero_a: assert property (
    nec_enable && net_floor_set == 2'h0 |=> nec_enable)
    else $error("network canceller dropped with zero floor");

  howl_hold_a: assert property (
    howl_seen && s_reg.w2[ecw_pkg::F_HOWL] ##1 s_reg.w2[ecw_pkg::F_HOWL] [*2]
    |-> half_duplex)
    else $error("howl hold released half-duplex");

  idle_tx_a: assert property (
    hd_state == ecw_pkg::HD_IDLE && half_duplex && s_reg.w2[ecw_pkg::F_IDLE] &&
    !rxd.speech && !howl_seen && !train_done |=> hd_state == ecw_pkg::HD_TX)
    else $error("idle did not return to transmit");

  coef_ctl_a: assert property (
    nec_coef_clear |-> !nec_coef_freeze &&
    $past(s_reg.w1[ecw_pkg::F_NCC +: 2]) == ecw_pkg::NCC_CLEAR)
    else $error("coefficient control decode wrong");

  mute_a: assert property (
    tx_mute |-> tx_gain_db == 8'h00 && !tx_agc_en)
    else $error("muted path shows gain");

endmodule
`default_nettype wire

/* rtl/ecw_pkg.sv */
package ecw_pkg;

  // ----------------------------------------
  // Register map and word codes
  // ----------------------------------------
  localparam logic [3:0]  OFS_CMD   = 4'h0;
  localparam logic [3:0]  OFS_WORD2 = 4'h4;
  localparam logic [3:0]  OFS_STAT  = 4'h8;
  localparam logic [3:0]  CODE_W1   = 4'h2;
  localparam logic [3:0]  CODE_W2   = 4'h4;
  localparam logic [15:0] W1_RST    = 16'h2a02;
  localparam logic [15:0] W2_RST    = 16'h0004;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int F_THR   = 14;
  localparam int F_TAPS  = 12;
  localparam int F_GAIN  = 8;
  localparam int F_RSUP  = 7;
  localparam int F_NCC   = 5;
  localparam int F_AUTO  = 4;
  localparam int F_STHR  = 12;
  localparam int F_RAMP  = 10;
  localparam int F_HOLD  = 8;
  localparam int F_HOWL  = 7;
  localparam int F_TDEC  = 6;
  localparam int F_RDEC  = 5;
  localparam int F_IDLE  = 4;

  // ----------------------------------------
  // Field values and figures
  // ----------------------------------------
  localparam logic [1:0] NCC_CLEAR   = 2'h1;
  localparam logic [1:0] NCC_FREEZE  = 2'h2;
  localparam logic [9:0] TAP_POOL    = 10'h1fc;
  localparam logic [9:0] TAP_STEP    = 10'h040;
  localparam logic [7:0] GAIN_MAX_DB = 8'h1e;
  localparam logic [7:0] GAIN_STEP   = 8'h03;
  localparam logic [3:0] GAIN_UNITY  = 4'ha;
  localparam logic [3:0] GAIN_MUTE   = 4'hf;
  localparam logic [4:0] RX_SUP_DB   = 5'h18;
  localparam logic [8:0] THR_BASE_DB = 9'h006;
  localparam logic [3:0] RAMP_BASE   = 4'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ    = 125000;
  localparam int HOLD_A_MS  = 200;
  localparam int HOLD_B_MS  = 100;
  localparam int HOLD_C_MS  = 150;
  localparam int HOLD_A_CYC = HOLD_A_MS * CLK_KHZ;
  localparam int HOLD_B_CYC = HOLD_B_MS * CLK_KHZ;
  localparam int HOLD_C_CYC = HOLD_C_MS * CLK_KHZ;

  typedef enum logic [3:0] {
    HD_IDLE = 4'b0001,
    HD_TX   = 4'b0010,
    HD_RX   = 4'b0100,
    HD_HOLD = 4'b1000
  } ecw_hd_e;

endpackage

/* rtl/ecw_det_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ecw_det_if;
  logic [7:0] pwr;
  logic [7:0] flr;
  logic [1:0] thr;
  logic       speech;
  modport det (input pwr, input flr, input thr, output speech);
  modport ctl (output pwr, output flr, output thr, input speech);
endinterface
`default_nettype wire

/* rtl/ecw_speech_det.sv */
`timescale 1ns/1ps
`default_nettype none
module ecw_speech_det (
  input wire logic mclk,     // Clock
  input wire logic rst,      // Sync reset
  ecw_det_if.det   d         // Power, floor, threshold
);
  typedef struct packed {
    logic speech;
  } ecw_det_s;

  ecw_det_s s_reg;
  ecw_det_s s_next;

  // Threshold code to dB, reserved code one 3 dB step above the top
  function automatic logic [8:0] thr_db(input logic [1:0] c);
    thr_db = ecw_pkg::THR_BASE_DB + 9'(3 * c);
  endfunction

  // Speech only above floor by the threshold
  always_comb begin
    s_next = s_reg;
    s_next.speech = {1'b0, d.pwr} > ({1'b0, d.flr} + thr_db(d.thr));
  end

  always_ff @(posedge mclk) begin
    if (rst) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign d.speech = s_reg.speech;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  speech_cause_a: assert property (
    ##1 d.speech == ({1'b0, $past(d.pwr)} > {1'b0, $past(d.flr)} + thr_db($past(d.thr))))
    else $error("speech flag not tied to power over floor");
endmodule
`default_nettype wire

/* rtl/ecw_hold_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ecw_hold_timer #(
  parameter int CNT_W = 25
) (
  input  wire logic             mclk,   // Clock
  input  wire logic             rst,    // Sync reset
  input  wire logic             run,    // Count while high
  input  wire logic [CNT_W-1:0] limit,  // Cycles to wait
  output logic                  done    // Delay elapsed
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } ecw_tmr_s;

  ecw_tmr_s s_reg;
  ecw_tmr_s s_next;

  // Counter must fit an int limit
  if (CNT_W < 1 || CNT_W > 31) begin : g_chk_w
    $error("holdover counter width out of range");
  end

  // Restart from zero whenever run drops
  always_comb begin
    s_next = s_reg;
    if (!run) begin
      s_next = '0;
    end else if (s_reg.cnt >= limit - 1'b1) begin
      s_next.done = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign done = s_reg.done;

  done_needs_run_a: assert property (@(posedge mclk) disable iff (rst)
    done |-> $past(run))
    else $error("holdover done without running");
endmodule
`default_nettype wire

/* sim/ecw_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ecw_host (
  input  wire logic        mclk,  // Clock
  output logic      [3:0]  addr,  // Address
  output logic      [15:0] wdata, // Write data
  output logic             wr,    // Write strobe
  output logic             rd,    // Read strobe
  input  wire logic [15:0] rdata  // Read data
);
  // ----
  // Host bus
  // ----
  // Quiet bus at time zero
  initial begin
    addr = 4'h0;
    wdata = 16'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write; stale data flipped so it is never reused
  task automatic put(input logic [3:0] a, input logic [15:0] w);
    @(posedge mclk);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    wdata <= ~w;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic get(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----
  // Harness
  // ----
  logic        mclk, rst, wr, rd, net_path_seen, howl_seen, train_done;
  logic        tx_speech, rx_speech, half_duplex, retrain, nec_enable, tx_agc_en;
  logic        nec_coef_clear, nec_coef_freeze, tx_mute, tx_decay_normal;
  logic        rx_decay_normal;
  logic [1:0]  net_floor_set;
  logic [3:0]  addr, hd_state, noise_ramp;
  logic [4:0]  rx_atten_db;
  logic [7:0]  tx_pwr, tx_flr, rx_pwr, rx_flr, tx_gain_db, g, f;
  logic [9:0]  aec_taps, nec_taps;
  logic [15:0] wdata, rdata, w, d;
  logic [15:0] bw[4] = '{16'h2a82, 16'h2a22, 16'h2a42, 16'h2a02};
  logic [15:0] be[4] = '{16'h0000, 16'h0058, 16'h0038, 16'h0018};
  int          i, lim, r0, rtr = 0, bad_count = 0, n_tests = 0;

  // Short holdover counts keep the run brief
  ecw_ctrl_words #(.HOLD_A_CYC(20), .HOLD_B_CYC(10), .HOLD_C_CYC(15)) uut (
    .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .tx_pwr, .tx_flr, .rx_pwr,
    .rx_flr, .net_floor_set, .net_path_seen, .howl_seen, .train_done,
    .tx_speech, .rx_speech, .hd_state, .half_duplex, .retrain, .aec_taps,
    .nec_taps, .nec_enable, .nec_coef_clear, .nec_coef_freeze, .tx_gain_db,
    .tx_agc_en, .tx_mute, .rx_atten_db, .noise_ramp, .tx_decay_normal,
    .rx_decay_normal);
  ecw_host host (.mclk, .addr, .wdata, .wr, .rd, .rdata);

  // Clock, 8 ns
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Retrain lasts one cycle, so count edges that see it
  always @(posedge mclk) if (retrain === 1'b1) rtr <= rtr + 1;

  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    n_tests++;
    if (a !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, a, e);
    end
  endtask
  // Ends just past an edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    host.get(a, d);
    chk(d, e);
  endtask
  // Both floors share one level
  task automatic lvl(input logic [7:0] tp, input logic [7:0] rp, input logic [7:0] fl);
    @(posedge mclk);
    tx_pwr <= tp;
    rx_pwr <= rp;
    tx_flr <= fl;
    rx_flr <= fl;
  endtask
  // Howl pulse if h, else training done
  task automatic pul(input logic h);
    @(posedge mclk);
    howl_seen <= h;
    train_done <= ~h;
    @(posedge mclk);
    howl_seen <= 1'b0;
    train_done <= 1'b0;
    cyc(3);
  endtask
  task automatic final_report;
    $display("%0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Run needs under 2000 cycles
  initial begin
    repeat (6000) @(posedge mclk);
    bad_count++;
    $display("watchdog expired");
    final_report();
  end

  // ----
  // Tests
  // ----
  initial begin
    rst = 1'b1;
    {tx_pwr, tx_flr, rx_pwr, rx_flr} = '0;
    {net_floor_set, net_path_seen, howl_seen, train_done} = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    cyc(1);
    chk(16'(aec_taps), 16'h013c);
    chk(16'({tx_agc_en, tx_mute, tx_gain_db}), 16'h0000);
    chk(16'({rx_atten_db, noise_ramp}), 16'h0183);
    chk(16'({half_duplex, nec_enable, hd_state}), 16'h0031);
    rchk(4'h0, 16'h2a02);
    rchk(4'h4, 16'h0004);
    $display("reset test ended");
    // Every split and gain code, read back as well
    for (i = 0; i < 16; i++) begin
      w = {2'b00, i[1:0], i[3:0], 8'h02};
      host.put(4'h0, w);
      cyc(2);
      g = (i == 15) ? 8'h00 : 8'(30 - 3 * i);
      chk(16'(aec_taps), 16'(444 - 64 * (i % 4)));
      chk(16'(aec_taps + nec_taps), 16'h01fc);
      chk(16'({tx_agc_en, tx_mute, tx_gain_db}), 16'({i < 10, i == 15, g}));
      rchk(4'h0, w);
    end
    // Suppression off, then clear, freeze, normal with quiet receive
    for (i = 0; i < 4; i++) begin
      host.put(4'h0, bw[i]);
      cyc(2);
      chk(16'({nec_coef_clear, nec_coef_freeze, rx_atten_db}), be[i]);
    end
    $display("first word test ended");
    // Power just at, then one above, floor plus threshold
    for (i = 0; i < 3; i++) begin
      host.put(4'h0, {i[1:0], 2'b10, 4'ha, 8'h02});
      host.put(4'h0, {i[1:0], i[1:0], i[1:0], 3'h0, i[0], i[1], 5'h04});
      cyc(2);
      chk(16'(noise_ramp), 16'(3 << i));
      chk(16'({tx_decay_normal, rx_decay_normal}), 16'({i[0], i[1]}));
      f = 8'(10 + 20 * i);
      g = 8'(f + 6 + 3 * i);
      lvl(g, g, f);
      cyc(4);
      chk(16'({tx_speech, rx_speech, rx_atten_db}), 16'h0018);
      lvl(g + 8'h01, g + 8'h01, f);
      cyc(4);
      chk(16'({tx_speech, rx_speech, rx_atten_db}), 16'h0060);
    end
    lvl(8'h00, 8'h00, 8'h0a);
    // Bad code and wrong offset are dropped; unmapped read is zero
    host.put(4'h0, 16'h6ab6);
    host.put(4'h4, 16'h0f02);
    rchk(4'h0, 16'haa02);
    rchk(4'h4, 16'ha824);
    rchk(4'hc, 16'h0000);
    host.put(4'h0, 16'h2a02);
    cyc(40);
    $display("routing test ended");
    // Holdover codes 0 to 2; receive talk inside the delay is ignored
    for (i = 0; i < 3; i++) begin
      lim = (i == 0) ? 20 : (i == 1) ? 10 : 15;
      host.put(4'h0, {6'h00, i[1:0], 3'h0, i == 2, 4'h4});
      lvl(8'h40, 8'h00, 8'h0a);
      cyc(6);
      chk(16'(hd_state), 16'h0002);
      lvl(8'h00, 8'h00, 8'h0a);
      cyc(4);
      chk(16'(hd_state), 16'h0008);
      lvl(8'h00, 8'h40, 8'h0a);
      cyc(lim - 8);
      chk(16'(hd_state), 16'h0008);
      lvl(8'h00, 8'h00, 8'h0a);
      // Idle lands lim+1 edges into holdover; idle return leaves it one edge later
      cyc(6);
      chk(16'(hd_state), (i == 2) ? 16'h0002 : 16'h0001);
    end
    $display("holdover test ended");
    // Howl without hold recovers on training; with hold it waits
    host.put(4'h0, {8'h00, 8'h04});
    pul(1'b0);
    chk(16'(half_duplex), 16'h0000);
    r0 = rtr;
    pul(1'b1);
    chk(16'({half_duplex, 8'(rtr - r0)}), 16'h0101);
    pul(1'b0);
    chk(16'(half_duplex), 16'h0000);
    host.put(4'h0, 16'h0084);
    pul(1'b1);
    pul(1'b0);
    chk(16'(half_duplex), 16'h0001);
    host.put(4'h0, 16'h0004);
    pul(1'b0);
    chk(16'(half_duplex), 16'h0000);
    $display("howl test ended");
    // Network canceller drops, stays off when barred, then re-engages
    chk(16'(nec_enable), 16'h0001);
    host.put(4'h0, 16'h2a12);
    net_floor_set <= 2'h1;
    cyc(3);
    chk(16'(nec_enable), 16'h0000);
    net_path_seen <= 1'b1;
    cyc(3);
    chk(16'(nec_enable), 16'h0000);
    net_path_seen <= 1'b0;
    host.put(4'h0, 16'h2a02);
    r0 = rtr;
    net_path_seen <= 1'b1;
    cyc(3);
    chk(16'({nec_enable, half_duplex, 8'(rtr - r0)}), 16'h0301);
    rchk(4'h8, 16'h001c);
    $display("network test ended");
    final_report();
  end
endmodule
`default_nettype wire
